// file: core/qct_regs.svh
// constants for the quad counter/timer/pwm/capture block
`ifndef QCT_REGS_SVH
`define QCT_REGS_SVH

`define QCT_CKSEL_EXT 2'b00
`define QCT_CKSEL_ONE 2'b01
`define QCT_CKSEL_TWO 2'b10

`define QCT_CAP_OFF 2'b00
`define QCT_CAP_RISE 2'b01
`define QCT_CAP_FALL 2'b10
`define QCT_CAP_BOTH 2'b11

`define QCT_PWM_SZ_A 2'b00
`define QCT_PWM_SZ_B 2'b01
`define QCT_PWM_SZ_C 2'b10
`define QCT_MASK_8 16'h00FF
`define QCT_MASK_10 16'h03FF
`define QCT_MASK_12 16'h0FFF
`define QCT_MASK_14 16'h3FFF
`define QCT_MASK_16 16'hFFFF

`define QCT_CLK_NS 100
`define QCT_DEB_NS 300
`define QCT_DEB_CYC ((`QCT_DEB_NS + `QCT_CLK_NS - 1) / `QCT_CLK_NS)

`endif

// file: core/qct_pkg.sv
// types shared by the quad counter/timer block
package qct_pkg;
  typedef struct packed {
    logic [7:0] counter_clock_select;
    logic [3:0] down_up;
    logic cascade_cd;
    logic cascade_ab;
    logic pwm1_en;
    logic pwm0_en;
    logic [1:0] cap_sel;
    logic [1:0] cap_func;
    logic [1:0] pwm1_size;
    logic [1:0] pwm0_size;
  } qct_cfg_t;

  typedef struct packed {
    logic ck128;
    logic ckrc_div4;
    logic ckrc;
    logic ck1k;
    logic ck32k;
  } qct_ticks_t;
endpackage

// file: core/qct_sync.sv
// two-flop level synchroniser
`timescale 1ns/1ps
module qct_sync #(
  parameter int unsigned W = 8
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] meta_r;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      meta_r <= '0;
      q_o <= '0;
    end else begin
      meta_r <= d_i;
      q_o <= meta_r;
    end
  end
endmodule // qct_sync

// file: core/qct_top.sv
// four 8-bit counters, pairable to 16 bits, with pwm and capture
// Behaviour
// - first and second counters chain to 16 bits
// - third and fourth counters chain likewise
// - two pwm outputs on port b pins
// - pwm widths 8, 10, 12, 14, 16
// - first pair captured on selected event
// - one capture signal serves both, chained or not
// - first pair: counters, captured, or pwm+captured
// - second pair: counters, or pwm plus counter
// - each counter picks one of four clocks
// - capture on rising, falling or both edges
// - counters raise interrupts and events
// - port a pins clock counters, debounced or direct
// - enable bits run or freeze counters
// - write sets compare; clears or loads count except on pwm counters
// - read returns count or captured value
// - code 00 selects the counter's own pin
`timescale 1ns/1ps
`include "qct_regs.svh"
module qct_top #(
  parameter int unsigned DEB_CYC = `QCT_DEB_CYC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire qct_pkg::qct_cfg_t cfg_i,
  input wire qct_pkg::qct_ticks_t ticks_i,
  input wire logic [3:0] counter_run_enable_i,
  input wire logic [3:0] cnt_wr_i,
  input wire logic [7:0] cnt_wdata_i,
  input wire logic [3:0] external_clock_pins_i,
  input wire logic [3:0] debounce_en_i,
  input wire logic [3:0] capture_src_i,
  output logic [3:0][7:0] cnt_rdata_o,
  output logic pwm_out_zero_pin_o,
  output logic pwm_out_one_pin_o,
  output logic [3:0] irq_o,
  output logic [3:0] event_o
);
  import qct_pkg::*;

  function automatic logic src_tick(input logic [1:0] sel, input logic second_pair,
                                    input logic ext, input qct_ticks_t t);
    case (sel)
      `QCT_CKSEL_EXT: src_tick = ext;
      `QCT_CKSEL_ONE: src_tick = second_pair ? t.ck32k : t.ckrc;
      `QCT_CKSEL_TWO: src_tick = second_pair ? t.ck1k : t.ckrc_div4;
      default: src_tick = t.ck128;
    endcase
  endfunction

  function automatic logic [15:0] pwm_mask(input logic [1:0] size, input logic casc);
    if (!casc) begin
      pwm_mask = `QCT_MASK_8;
    end else begin
      case (size)
        `QCT_PWM_SZ_A: pwm_mask = `QCT_MASK_10;
        `QCT_PWM_SZ_B: pwm_mask = `QCT_MASK_12;
        `QCT_PWM_SZ_C: pwm_mask = `QCT_MASK_14;
        default: pwm_mask = `QCT_MASK_16;
      endcase
    end
  endfunction

  // returns {match, next count}
  function automatic logic [16:0] step(input logic [15:0] v, input logic [15:0] c,
                                       input logic [15:0] mask, input logic up,
                                       input logic pwm);
    logic [15:0] nv;
    logic hit;
    nv = '0;
    hit = 1'b0;
    if (pwm) begin
      nv = (v + 16'h0001) & mask;
      hit = (nv == 16'h0000);
    end else if (up) begin
      hit = (v == c);
      nv = hit ? 16'h0000 : ((v + 16'h0001) & mask);
    end else begin
      hit = (v == 16'h0000);
      nv = hit ? c : ((v - 16'h0001) & mask);
    end
    step = {hit, nv};
  endfunction

  logic [7:0] s_w;
  logic [7:0] s_prev_r;
  logic [3:0] deb_lvl_r, deb_lvl_nxt;
  logic [3:0][7:0] deb_cnt_r, deb_cnt_nxt;
  logic [3:0] pin_prev_r;
  logic [3:0] pin_lvl;
  logic [3:0] tick;
  logic cap_ev;
  logic [3:0][7:0] cnt_r, cnt_nxt;
  logic [3:0][7:0] cmp_r, cmp_nxt;
  logic [1:0][7:0] cap_r, cap_nxt;
  logic [3:0] hit;
  logic [1:0] pwm_lvl;
  logic [1:0] casc_w;
  logic [1:0] pwm_w;
  logic [3:0][7:0] rd_nxt;
  logic pwm0_nxt, pwm1_nxt;

  // the capture sources go through the same synchroniser as the pins
  qct_sync #(.W(8)) u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i({capture_src_i, external_clock_pins_i}),
    .q_o(s_w)
  );

  assign casc_w = {cfg_i.cascade_cd, cfg_i.cascade_ab};
  assign pwm_w = {cfg_i.pwm1_en, cfg_i.pwm0_en};

  // pin path: debounce, edge detect, clock select
  always_comb begin
    logic cl;
    logic cp;
    cl = 1'b0;
    cp = 1'b0;
    deb_lvl_nxt = deb_lvl_r;
    deb_cnt_nxt = deb_cnt_r;
    for (int i = 0; i < 4; i++) begin
      // a level must hold DEB_CYC cycles before it is believed
      if (s_w[i] == deb_lvl_r[i]) begin
        deb_cnt_nxt[i] = 8'h00;
      end else if (deb_cnt_r[i] >= 8'(DEB_CYC - 1)) begin
        deb_lvl_nxt[i] = s_w[i];
        deb_cnt_nxt[i] = 8'h00;
      end else begin
        deb_cnt_nxt[i] = deb_cnt_r[i] + 8'h01;
      end
      pin_lvl[i] = debounce_en_i[i] ? deb_lvl_r[i] : s_w[i];
      tick[i] = src_tick(cfg_i.counter_clock_select[2*i +: 2], i >= 2,
                         pin_lvl[i] & ~pin_prev_r[i], ticks_i);
    end
    cl = s_w[3'(4 + cfg_i.cap_sel)];
    cp = s_prev_r[3'(4 + cfg_i.cap_sel)];
    case (cfg_i.cap_func)
      `QCT_CAP_RISE: cap_ev = cl & ~cp;
      `QCT_CAP_FALL: cap_ev = ~cl & cp;
      `QCT_CAP_BOTH: cap_ev = cl ^ cp;
      default: cap_ev = 1'b0;
    endcase
  end

  always_comb begin
    logic [15:0] v;
    logic [15:0] c;
    logic [15:0] m;
    logic [16:0] r;
    logic pk;
    logic up;
    int lo;
    v = '0;
    c = '0;
    m = '0;
    r = '0;
    pk = 1'b0;
    up = 1'b0;
    lo = 0;
    cnt_nxt = cnt_r;
    cmp_nxt = cmp_r;
    hit = '0;
    pwm_lvl = '0;
    for (int p = 0; p < 2; p++) begin
      lo = 2 * p;
      if (casc_w[p]) begin
        // chained pair runs on the low counter's clock, enable and direction
        m = pwm_w[p] ? pwm_mask(p == 0 ? cfg_i.pwm0_size : cfg_i.pwm1_size, 1'b1)
                     : `QCT_MASK_16;
        v = {cnt_r[lo+1], cnt_r[lo]};
        c = {cmp_r[lo+1], cmp_r[lo]};
        r = step(v, c, m, cfg_i.down_up[lo], pwm_w[p]);
        if (counter_run_enable_i[lo] && tick[lo]) begin
          cnt_nxt[lo] = r[7:0];
          cnt_nxt[lo+1] = r[15:8];
          hit[lo] = r[16];
        end
        pwm_lvl[p] = (v & m) < (c & m);
      end else begin
        for (int k = 0; k < 2; k++) begin
          pk = pwm_w[p] && (k == 0);
          r = step({8'h00, cnt_r[lo+k]}, {8'h00, cmp_r[lo+k]}, `QCT_MASK_8,
                   cfg_i.down_up[lo+k], pk);
          if (counter_run_enable_i[lo+k] && tick[lo+k]) begin
            cnt_nxt[lo+k] = r[7:0];
            hit[lo+k] = r[16];
          end
        end
        pwm_lvl[p] = cnt_r[lo] < cmp_r[lo];
      end
    end
    // on non-pwm counters a write wins over a count step in the same cycle; a pwm count still steps
    for (int i = 0; i < 4; i++) begin
      lo = (i / 2) * 2;
      pk = pwm_w[i/2] && (casc_w[i/2] || (i == lo));
      up = casc_w[i/2] ? cfg_i.down_up[lo] : cfg_i.down_up[i];
      if (cnt_wr_i[i]) begin
        cmp_nxt[i] = cnt_wdata_i;
        if (!pk) begin
          cnt_nxt[i] = up ? 8'h00 : cnt_wdata_i;
        end
      end
    end
  end

  always_comb begin
    cap_nxt = cap_ev ? {cnt_r[1], cnt_r[0]} : cap_r;
    for (int i = 0; i < 4; i++) begin
      rd_nxt[i] = (i < 2 && cfg_i.cap_func != `QCT_CAP_OFF) ? cap_r[i % 2] : cnt_r[i];
    end
    pwm0_nxt = cfg_i.pwm0_en & pwm_lvl[0];
    pwm1_nxt = cfg_i.pwm1_en & pwm_lvl[1];
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      s_prev_r <= '0;
      deb_lvl_r <= '0;
      deb_cnt_r <= '0;
      pin_prev_r <= '0;
      cnt_r <= '0;
      cmp_r <= '0;
      cap_r <= '0;
      cnt_rdata_o <= '0;
      pwm_out_zero_pin_o <= 1'b0;
      pwm_out_one_pin_o <= 1'b0;
      irq_o <= '0;
      event_o <= '0;
    end else begin
      s_prev_r <= s_w;
      deb_lvl_r <= deb_lvl_nxt;
      deb_cnt_r <= deb_cnt_nxt;
      pin_prev_r <= pin_lvl;
      cnt_r <= cnt_nxt;
      cmp_r <= cmp_nxt;
      cap_r <= cap_nxt;
      cnt_rdata_o <= rd_nxt;
      pwm_out_zero_pin_o <= pwm0_nxt;
      pwm_out_one_pin_o <= pwm1_nxt;
      irq_o <= hit;
      event_o <= hit;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  wr_compare_a: assert property (cnt_wr_i[0] |=> cmp_r[0] == $past(cnt_wdata_i))
    else $error("compare value not written");
  up_clear_a: assert property (cnt_wr_i[0] && !cfg_i.pwm0_en && cfg_i.down_up[0]
    |=> cnt_r[0] == 8'h00)
    else $error("up counter not cleared on write");
  pwm_keep_a: assert property (cnt_wr_i[0] && cfg_i.pwm0_en
    && !(counter_run_enable_i[0] && tick[0]) |=> $stable(cnt_r[0]))
    else $error("pwm count changed by write");
  run_freeze_a: assert property (!counter_run_enable_i[0] && !cnt_wr_i[0]
    |=> $stable(cnt_r[0]))
    else $error("disabled counter moved");
  chain_enable_a: assert property (cfg_i.cascade_ab && !counter_run_enable_i[0]
    && !cnt_wr_i[1] |=> $stable(cnt_r[1]))
    else $error("chained high counter moved while low disabled");
  capture_take_a: assert property (cap_ev |=> cap_r[0] == $past(cnt_r[0])
    && cap_r[1] == $past(cnt_r[1]))
    else $error("capture missed a counter");
  read_capture_a: assert property (cfg_i.cap_func != `QCT_CAP_OFF
    |=> cnt_rdata_o[1] == $past(cap_r[1]))
    else $error("read did not return captured value");
  // the pulse may only stretch while matches keep coming
  irq_match_a: assert property (hit[0] |=> irq_o[0] && event_o[0]
    ##1 (irq_o[0] == $past(hit[0])))
    else $error("interrupt not raised on match");
  pwm_idle_a: assert property (!cfg_i.pwm0_en |=> !pwm_out_zero_pin_o)
    else $error("pwm pin driven while disabled");
  pwm_one_idle_a: assert property (!cfg_i.pwm1_en |=> !pwm_out_one_pin_o)
    else $error("second pwm pin driven while disabled");
  irq_event_pair_a: assert property (irq_o == event_o)
    else $error("interrupt and event disagree");
  down_load_a: assert property (cnt_wr_i[0] && !cfg_i.pwm0_en && !cfg_i.down_up[0]
    |=> cnt_r[0] == $past(cnt_wdata_i))
    else $error("down counter not loaded on write");
  read_count_a: assert property (cfg_i.cap_func == `QCT_CAP_OFF
    |=> cnt_rdata_o[0] == $past(cnt_r[0]))
    else $error("read did not return live count");
  read_live_a: assert property (1'b1 |=> cnt_rdata_o[2] == $past(cnt_r[2]))
    else $error("third counter read not live");
  capture_hold_a: assert property (!cap_ev |=> $stable(cap_r))
    else $error("capture register moved without event");
  // chained pairs report on the low index only
  irq_low_only_a: assert property (cfg_i.cascade_ab |=> !irq_o[1])
    else $error("chained high counter raised interrupt");
  chain_carry_a: assert property (cfg_i.cascade_ab && !cfg_i.pwm0_en && cfg_i.down_up[0]
    && counter_run_enable_i[0] && tick[0] && cnt_r[0] == 8'hFF && !hit[0]
    && cnt_wr_i == 4'h0 |=> cnt_r[1] == $past(cnt_r[1]) + 8'h01)
    else $error("chained carry lost");
  ext_tick_a: assert property (cfg_i.counter_clock_select[1:0] == `QCT_CKSEL_EXT
    && !cnt_wr_i[0] && !(pin_lvl[0] && !pin_prev_r[0]) |=> $stable(cnt_r[0]))
    else $error("counter moved without its pin edge");
  pwm_wrap_a: assert property (cfg_i.pwm0_en && !cfg_i.cascade_ab && counter_run_enable_i[0]
    && tick[0] && cnt_r[0] == 8'hFF && !cnt_wr_i[0]
    |=> cnt_r[0] == 8'h00 ##1 irq_o[0])
    else $error("8-bit pwm did not wrap");
  // 10-bit chained pwm must wrap at its own mask, not at 16 bits
  pwm_mask_a: assert property (cfg_i.cascade_ab && cfg_i.pwm0_en
    && cfg_i.pwm0_size == `QCT_PWM_SZ_A && counter_run_enable_i[0] && tick[0]
    && {cnt_r[1], cnt_r[0]} == `QCT_MASK_10 && cnt_wr_i[1:0] == 2'b00
    |=> {cnt_r[1], cnt_r[0]} == 16'h0000)
    else $error("chained pwm width wrong");
endmodule // qct_top

// file: verification/qct_top_test.sv
// self-checking bench for the quad counter/timer block
`timescale 1ns/1ps
module qct_top_test;
  import qct_pkg::*;
  logic clk_i = 0;
  logic rst_i = 1;
  qct_cfg_t cfg = '0;
  qct_ticks_t tk = '1;
  logic [3:0] en = 0, wr = 0, pins = 0, deb = 0, cap = 0, r;
  logic [7:0] wd = 0, w, e, cap_e;
  logic [3:0][7:0] rd;
  logic pwm0, pwm1;
  logic [3:0] irq, evn;
  int n_fail = 0, tests_run = 0, cyc = 0, seed = 32'h5601_6fd3, j, k;
  int hits [8];
  int pc [4];
  qct_top #(.DEB_CYC(1)) uut (.clk_i(clk_i), .rst_i(rst_i), .cfg_i(cfg), .ticks_i(tk),
    .counter_run_enable_i(en), .cnt_wr_i(wr), .cnt_wdata_i(wd), .external_clock_pins_i(pins),
    .debounce_en_i(deb), .capture_src_i(cap), .cnt_rdata_o(rd), .pwm_out_zero_pin_o(pwm0),
    .pwm_out_one_pin_o(pwm1), .irq_o(irq), .event_o(evn));
  initial forever #50 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    for (int i = 0; i < 4; i++) begin
      if (irq[i] === 1'b1) hits[i] <= hits[i] + 1;
      if (evn[i] === 1'b1) hits[i+4] <= hits[i+4] + 1;
    end
    if (cyc == 5000) begin
      n_fail++;
      end_of_test();
    end
  end
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wrt(input logic [3:0] m, input logic [7:0] d);
    @(posedge clk_i);
    wr <= m;
    wd <= d;
    @(posedge clk_i);
    wr <= 0;
    repeat (3) @(posedge clk_i);
  endtask
  // enable held for exactly n sampling edges
  task automatic run(input logic [3:0] m, input int n);
    @(posedge clk_i);
    en <= m;
    repeat (n) @(posedge clk_i);
    en <= 0;
    repeat (4) @(posedge clk_i);
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    hits = '{default: 0};
    repeat (16) @(posedge clk_i);
    rst_i <= 0;
    @(posedge clk_i);
    chk("reset rdata", 16'(rd[0] | rd[1] | rd[2] | rd[3]), 0);
    chk("reset outs", {pwm0, pwm1, irq, evn}, 0);
    // code 11 with an always-high tick: one step per cycle
    cfg.counter_clock_select <= 8'hFF;
    for (int d = 0; d < 2; d++) begin
      cfg.down_up <= {4{d[0]}};
      for (int i = 0; i < 4; i++) begin
        w = 8'(2 + $unsigned($random(seed)) % 20);
        j = $unsigned($random(seed)) % w;
        wrt(4'b1 << i, w);
        chk("write", rd[i], d ? 0 : w);
        hits = '{default: 0};
        run(4'b1 << i, w + 1 + j);
        e = d ? 8'(j) : 8'(w - j);
        chk("count", rd[i], e);
        chk("irq", hits[i], 1);
        chk("event", hits[i+4], 1);
        repeat (5) @(posedge clk_i);
        chk("frozen", rd[i], e);
      end
    end
    // high halves keep enable low: low enables must govern them
    cfg.down_up <= 4'hF;
    cfg.cascade_ab <= 1;
    cfg.cascade_cd <= 1;
    wrt(4'hF, 8'hFF);
    run(4'b0101, 300);
    for (int i = 0; i < 4; i++) chk("chain", rd[i], i[0] ? 8'h01 : 8'h2C);
    cfg.cascade_ab <= 0;
    cfg.cascade_cd <= 0;
    cfg.counter_clock_select <= 8'h00;
    deb <= 4'($random(seed));
    wrt(4'hF, 8'hFF);
    pc = '{default: 0};
    @(posedge clk_i);
    en <= 4'hF;
    repeat (12) begin
      r = 4'($random(seed));
      pins <= r;
      repeat (4) @(posedge clk_i);
      pins <= 0;
      repeat (4) @(posedge clk_i);
      for (int i = 0; i < 4; i++) pc[i] += r[i];
    end
    repeat (6) @(posedge clk_i);
    en <= 0;
    repeat (4) @(posedge clk_i);
    for (int i = 0; i < 4; i++) chk("ext clock", rd[i], pc[i]);
    // all capture sources move together so a select change makes no edge
    cfg.counter_clock_select <= 8'hFF;
    wrt(4'h3, 8'hFF);
    cap_e = 0;
    k = 0;
    for (int f = 1; f < 4; f++) begin
      cfg.cap_sel <= 2'($random(seed));
      cfg.cap_func <= 2'(f);
      cap <= 4'hF;
      repeat (6) @(posedge clk_i);
      if (f[0]) cap_e = 8'(k);
      run(4'h3, 10);
      k += 10;
      chk("capture rise", rd[0], cap_e);
      chk("capture shared", rd[1], cap_e);
      cap <= 0;
      repeat (6) @(posedge clk_i);
      if (f[1]) cap_e = 8'(k);
      chk("capture fall", rd[0], cap_e);
      chk("capture second", rd[1], cap_e);
    end
    cfg.cap_func <= 0;
    cfg.pwm0_en <= 1;
    cfg.pwm1_en <= 1;
    for (int t = 0; t < 6; t++) begin
      w = (t < 2) ? 8'(k + t) : 8'($random(seed));
      wrt(4'h5, w);
      chk("pwm count kept", rd[0], k);
      chk("pwm zero", pwm0, 16'(k < w));
      chk("pwm one", pwm1, 16'(pc[2] < w));
    end
    end_of_test();
  end
endmodule // qct_top_test
